// ==== rtl/dqvref_regs.svh ====
// constants for the data input reference level select pair
// assumes a 25 MHz clock shared by controller and device end
`ifndef DQVREF_REGS_SVH
`define DQVREF_REGS_SVH

// ****************************************
// training control word layout
// ****************************************
`define DQV_TRAIN_BIT 7
`define DQV_RANGE_BIT 6
`define DQV_LEVEL_MSB 5
`define DQV_LEVEL_MAX 6'h32
`define DQV_CTRL_RST 8'h00

// ****************************************
// reference levels in hundredths of a percent
// ****************************************
`define DQV_BASE_R1 14'h1770
`define DQV_BASE_R2 14'h1194
`define DQV_STEP 14'h0041
`define DQV_TOP_R1 14'h2422
`define DQV_TOP_R2 14'h1E46

// ****************************************
// timing figures
// ****************************************
`define DQV_CLK_PERIOD_NS 40
`define DQV_SETTLE_NS 150
`define DQV_POWERUP_PULSE_US 200
`define DQV_WARM_PULSE_US 1

// ****************************************
// controller register byte offsets and bits
// ****************************************
`define DQV_REG_CMD 4'h0
`define DQV_REG_CAL 4'h4
`define DQV_REG_STATUS 4'h8
`define DQV_CAL_ACTIVE_BIT 0
`define DQV_CAL_WARM_BIT 1
`define DQV_ST_INRESET_BIT 0
`define DQV_ST_CAL_BIT 1
`define DQV_ST_RESERR_BIT 2
`define DQV_ST_BUSYERR_BIT 3

`endif

// ==== rtl/dqvref_pkg.sv ====
// types used by the controller end of the reference level select link
// assumes the constants header is included by the modules
package dqvref_pkg;

    // ****************************************
    // controller sequencing states
    // ****************************************
    typedef enum logic [1:0] {
        DQV_ST_POWERUP = 2'b00,
        DQV_ST_IDLE = 2'b01,
        DQV_ST_WARM = 2'b10
    } dqvref_ctl_state_t;

endpackage

// ==== rtl/dqvref_if.sv ====
// link between memory controller end and device end
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface dqvref_if;
    logic reset_n; // active-low device reset
    logic mrw_valid; // one-cycle mode register write command
    logic [7:0] mrw_data; // training control word

    modport ctrl (output reset_n, output mrw_valid, output mrw_data);
    modport dev (input reset_n, input mrw_valid, input mrw_data);
endinterface

// ==== rtl/dqvref_device.sv ====
// device end: decodes training control writes into a reference level
// assumes the link comes from logic on clk_i, so no synchroniser is used
`timescale 1ns/1ps
`include "dqvref_regs.svh"

// Function
// - bit six picks range, range one 60-92.5%
// - range two spans 45 to 77.5%
// - low six bits step level from base
// - apply fields regardless of training enable bit
// - controller sets training enable when changing fields; code compares with its last sent word, which a warm reset does not clear
// - controller keeps training enable during calibration
// - controller never writes reserved level codes
// - power-up reset held at least 200 us
// - warm reset held at least 1 us
// - any reset marks stored data lost
// - new level settles within 150 ns
module dqvref_device (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link from the controller
    dqvref_if.dev link,
    // decoded reference setting
    output logic ref_range_o,
    output logic [5:0] ref_level_o,
    output logic train_enable_o,
    output logic [13:0] ref_percent_o,
    output logic ref_settled_o,
    // error and data state
    output logic reserved_code_o,
    output logic data_lost_o,
    input wire logic data_lost_clr_i
);

    // ****************************************
    // timing
    // ****************************************

    // longest settle time, rounded down to whole cycles
    localparam int SETTLE_CYC = `DQV_SETTLE_NS / `DQV_CLK_PERIOD_NS;
    localparam logic [2:0] SETTLE_LOAD = 3'(SETTLE_CYC);
    // three edges of the 40 ns clock keep a move inside the settle limit

    // ****************************************
    // reset values
    // ****************************************

    // settings after any reset follow the default control word
    localparam logic [7:0] RST_WORD = `DQV_CTRL_RST;
    localparam logic RST_RANGE = RST_WORD[`DQV_RANGE_BIT]; // range after reset
    localparam logic [5:0] RST_LEVEL = RST_WORD[`DQV_LEVEL_MSB:0]; // code after reset
    localparam logic RST_TRAIN = RST_WORD[`DQV_TRAIN_BIT]; // training bit after reset
    // the default word selects range one, so its level is the range one base
    localparam logic [13:0] RST_PCT = `DQV_BASE_R1;

    // ****************************************
    // state
    // ****************************************

    logic range; // held range select
    logic [5:0] level; // held level code
    logic train; // held training enable bit
    logic [13:0] target; // level being moved to
    logic [13:0] applied; // level currently presented
    logic [2:0] timer; // settle countdown
    logic settled; // applied equals target
    logic reserved; // last write carried a reserved code
    logic lost; // stored data undefined since a reset

    logic next_range;
    logic [5:0] next_level;
    logic next_train;
    logic [13:0] next_target;
    logic [13:0] next_applied;
    logic [2:0] next_timer;
    logic next_settled;
    logic next_reserved;
    logic next_lost;

    // ****************************************
    // level arithmetic
    // ****************************************

    // level in hundredths of a percent for a range and a code
    function automatic logic [13:0] level_of(input logic rng, input logic [5:0] code);
        logic [13:0] base;
        base = `DQV_BASE_R1; // range one base of 60.00
        if (rng) begin
            base = `DQV_BASE_R2; // range two base of 45.00
        end
        // each code step adds 0.65% of the supply
        return base + 14'(code) * `DQV_STEP;
    endfunction

    // code carried in the incoming word
    logic [5:0] in_code;
    // incoming word names a reserved level
    logic in_reserved;

    assign in_code = link.mrw_data[`DQV_LEVEL_MSB:0];
    assign in_reserved = (in_code > `DQV_LEVEL_MAX);

    // ****************************************
    // next state
    // ****************************************

    // the controller end refuses reserved codes, so one arriving here means
    // a faulty controller; the held setting is kept rather than guessing a
    // level, and a move already under way still finishes on time
    // decode writes, run settle timer, track data loss
    always_comb begin
        next_range = range;
        next_level = level;
        next_train = train;
        next_target = target;
        next_applied = applied;
        next_timer = timer;
        next_settled = settled;
        next_reserved = reserved;
        next_lost = lost;
        if (!link.reset_n) begin
            // device reset: settings to defaults, data undefined
            next_range = RST_RANGE;
            next_level = RST_LEVEL;
            next_train = RST_TRAIN;
            next_target = RST_PCT;
            next_applied = RST_PCT;
            next_timer = 3'h0;
            next_settled = 1'b1;
            next_reserved = 1'b0;
            next_lost = 1'b1; // set beats any clear
        end else begin
            // user acknowledges the loss
            if (data_lost_clr_i) begin
                next_lost = 1'b0;
            end
            if (link.mrw_valid && !in_reserved) begin
                // bit six picks the range
                next_range = link.mrw_data[`DQV_RANGE_BIT];
                // fields apply whatever the training bit says
                next_level = in_code;
                next_train = link.mrw_data[`DQV_TRAIN_BIT];
                next_target = level_of(link.mrw_data[`DQV_RANGE_BIT], in_code);
                // restart settling, done inside the limit
                next_timer = SETTLE_LOAD;
                next_settled = 1'b0;
                next_reserved = 1'b0;
            end else if (timer != 3'h0) begin
                // a refused word must not stall the countdown
                next_timer = timer - 3'h1;
                if (timer == 3'h1) begin
                    // one step or full range, same limit
                    next_applied = target;
                    next_settled = 1'b1;
                end
            end
            if (link.mrw_valid && in_reserved) begin
                // no defined level: keep previous setting, flag it
                next_reserved = 1'b1;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************

    // register state; local reset also marks data lost
    // a local reset and a link reset leave the same state behind
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            range <= RST_RANGE;
            level <= RST_LEVEL;
            train <= RST_TRAIN;
            target <= RST_PCT;
            applied <= RST_PCT;
            timer <= 3'h0;
            settled <= 1'b1;
            reserved <= 1'b0;
            lost <= 1'b1;
        end else begin
            range <= next_range;
            level <= next_level;
            train <= next_train;
            target <= next_target;
            applied <= next_applied;
            timer <= next_timer;
            settled <= next_settled;
            reserved <= next_reserved;
            lost <= next_lost;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    // every output is a flop of the state above
    // settled stays low while the presented level is still moving
    assign ref_range_o = range;
    assign ref_level_o = level;
    assign train_enable_o = train;
    assign ref_percent_o = applied;
    assign ref_settled_o = settled;
    assign reserved_code_o = reserved;
    assign data_lost_o = lost;

endmodule

// ==== rtl/dqvref_ctrl.sv ====
// controller end: wishbone registers drive device reset and training writes
// assumes a classic wishbone master on clk_i
`timescale 1ns/1ps
`include "dqvref_regs.svh"

module dqvref_ctrl #(
    // power-up reset length in cycles, rounded up from 200 us
    parameter int POWERUP_CYC = (`DQV_POWERUP_PULSE_US * 1000 + `DQV_CLK_PERIOD_NS - 1)
                                / `DQV_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // link to the device
    dqvref_if.ctrl link
);

    // ****************************************
    // timing
    // ****************************************

    // warm reset length, rounded up from 1 us
    localparam int WARM_CYC = (`DQV_WARM_PULSE_US * 1000 + `DQV_CLK_PERIOD_NS - 1)
                              / `DQV_CLK_PERIOD_NS;

    // ****************************************
    // state
    // ****************************************

    dqvref_pkg::dqvref_ctl_state_t state, next_state;
    logic [31:0] cnt, next_cnt; // reset pulse cycle count
    logic rstn, next_rstn; // device reset drive
    logic mrw, next_mrw; // command strobe
    logic [7:0] cmd, next_cmd; // last word sent
    logic cal, next_cal; // calibration in progress
    logic res_err, next_res_err; // reserved code refused
    logic busy_err, next_busy_err; // write refused during reset
    logic ack, next_ack; // bus acknowledge
    logic [31:0] rdat, next_rdat; // bus read data

    logic req; // new bus cycle
    logic wr; // write with low byte enabled
    logic [7:0] wbyte; // written low byte
    logic [7:0] send; // word to send

    assign req = wb_cyc_i & wb_stb_i & ~ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    // ****************************************
    // next state
    // ****************************************

    // bus decode, reset sequencing and command issue
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_rstn = rstn;
        next_mrw = 1'b0;
        next_cmd = cmd;
        next_cal = cal;
        next_res_err = res_err;
        next_busy_err = busy_err;
        next_ack = req;
        next_rdat = 32'h0000_0000;
        // training bit forced on a change or during calibration
        send = wbyte;
        if (cal || (wbyte[`DQV_RANGE_BIT:0] != cmd[`DQV_RANGE_BIT:0])) begin
            send[`DQV_TRAIN_BIT] = 1'b1;
        end
        // status clears first so a same-cycle set wins below
        if (wr && wb_adr_i == `DQV_REG_STATUS) begin
            if (wbyte[`DQV_ST_RESERR_BIT]) begin
                next_res_err = 1'b0;
            end
            if (wbyte[`DQV_ST_BUSYERR_BIT]) begin
                next_busy_err = 1'b0;
            end
        end
        // reads
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `DQV_REG_CMD: next_rdat = {24'h00_0000, cmd};
                `DQV_REG_CAL: next_rdat = {31'h0000_0000, cal};
                `DQV_REG_STATUS: begin
                    next_rdat[`DQV_ST_INRESET_BIT] = (state != dqvref_pkg::DQV_ST_IDLE);
                    next_rdat[`DQV_ST_CAL_BIT] = cal;
                    next_rdat[`DQV_ST_RESERR_BIT] = res_err;
                    next_rdat[`DQV_ST_BUSYERR_BIT] = busy_err;
                end
                default: next_rdat = 32'h0000_0000;
            endcase
        end
        // calibration flag
        if (wr && wb_adr_i == `DQV_REG_CAL) begin
            next_cal = wbyte[`DQV_CAL_ACTIVE_BIT];
        end
        case (state)
            dqvref_pkg::DQV_ST_POWERUP: begin
                // hold reset low for the power-up pulse
                next_rstn = 1'b0;
                next_cnt = cnt + 32'h1;
                if (cnt >= 32'(POWERUP_CYC - 1)) begin
                    next_state = dqvref_pkg::DQV_ST_IDLE;
                    next_rstn = 1'b1;
                    next_cnt = 32'h0;
                end
            end
            dqvref_pkg::DQV_ST_WARM: begin
                // hold reset low for the warm pulse
                next_rstn = 1'b0;
                next_cnt = cnt + 32'h1;
                if (cnt >= 32'(WARM_CYC - 1)) begin
                    next_state = dqvref_pkg::DQV_ST_IDLE;
                    next_rstn = 1'b1;
                    next_cnt = 32'h0;
                end
            end
            default: begin
                if (wr && wb_adr_i == `DQV_REG_CMD) begin
                    if (wbyte[`DQV_LEVEL_MSB:0] > `DQV_LEVEL_MAX) begin
                        next_res_err = 1'b1; // never sent
                    end else begin
                        next_mrw = 1'b1;
                        next_cmd = send;
                    end
                end
                if (wr && wb_adr_i == `DQV_REG_CAL && wbyte[`DQV_CAL_WARM_BIT]) begin
                    // device data is lost after this
                    next_state = dqvref_pkg::DQV_ST_WARM;
                    next_rstn = 1'b0;
                    next_cnt = 32'h0;
                end
            end
        endcase
        // command writes while the device is in reset are refused
        if (wr && wb_adr_i == `DQV_REG_CMD && state != dqvref_pkg::DQV_ST_IDLE) begin
            next_busy_err = 1'b1;
        end
    end

    // ****************************************
    // registers
    // ****************************************

    // register state; reset restarts the power-up pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= dqvref_pkg::DQV_ST_POWERUP;
            cnt <= 32'h0;
            rstn <= 1'b0;
            mrw <= 1'b0;
            cmd <= `DQV_CTRL_RST;
            cal <= 1'b0;
            res_err <= 1'b0;
            busy_err <= 1'b0;
            ack <= 1'b0;
            rdat <= 32'h0000_0000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            rstn <= next_rstn;
            mrw <= next_mrw;
            cmd <= next_cmd;
            cal <= next_cal;
            res_err <= next_res_err;
            busy_err <= next_busy_err;
            ack <= next_ack;
            rdat <= next_rdat;
        end
    end

    // ****************************************
    // outputs
    // ****************************************

    assign wb_ack_o = ack;
    assign wb_dat_o = rdat;
    assign link.reset_n = rstn;
    assign link.mrw_valid = mrw;
    assign link.mrw_data = cmd;

endmodule

// ==== dv/dqvref_properties.sv ====
// checker for the link between controller end and device end
// assumes every link signal is launched from clk_i
`timescale 1ns/1ps
`include "dqvref_regs.svh"

module dqvref_properties #(
    parameter int POWERUP_CYC = 5000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link signals
    input wire logic reset_n,
    input wire logic mrw_valid,
    input wire logic [7:0] mrw_data
);
    // ********
    // helper state
    // ********
    logic [15:0] low_cnt; // edges seen with device reset low
    logic [15:0] next_low_cnt;
    logic seen_up; // device reset released once since rst_i
    logic next_seen_up;
    logic [6:0] last_sent; // fields of the last word sent
    logic [6:0] next_last_sent;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // next helper values
    always_comb begin
        next_low_cnt = reset_n ? 16'h0000 : low_cnt + 16'h0001;
        next_seen_up = seen_up | reset_n;
        next_last_sent = mrw_valid ? mrw_data[6:0] : last_sent;
    end

    // helper registers, cleared by rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_cnt <= 16'h0000;
            seen_up <= 1'b0;
            last_sent <= 7'h00;
        end else begin
            low_cnt <= next_low_cnt;
            seen_up <= next_seen_up;
            last_sent <= next_last_sent;
        end
    end

    // ********
    // link rules
    // ********
    a_code_in_range: assert property (mrw_valid |-> mrw_data[5:0] <= `DQV_LEVEL_MAX)
        else $error("reserved level code sent");
    a_train_on_change: assert property (mrw_valid && mrw_data[6:0] != last_sent |-> mrw_data[7])
        else $error("field change sent without training enable");
    a_quiet_in_reset: assert property (!reset_n |-> !mrw_valid)
        else $error("write sent while device held in reset");
    a_single_pulse: assert property (mrw_valid |=> !mrw_valid)
        else $error("write command longer than one cycle");
    a_word_held: assert property (!mrw_valid |-> $stable(mrw_data))
        else $error("word changed without a write command");
    a_powerup_length: assert property ($rose(reset_n) && !seen_up |->
        low_cnt >= POWERUP_CYC && low_cnt <= POWERUP_CYC + 2)
        else $error("power-up reset pulse length wrong");
    a_warm_min_length: assert property ($rose(reset_n) && seen_up |-> low_cnt >= 25)
        else $error("warm reset pulse too short");
    a_warm_max_length: assert property (seen_up && !reset_n |-> low_cnt < 30)
        else $error("warm reset pulse too long");

    // main scenarios
    c_forced_train: cover property (mrw_valid && mrw_data[7]);
    c_range_two: cover property (mrw_valid && mrw_data[6]);
    c_warm_release: cover property ($rose(reset_n) && seen_up);
endmodule

// ==== dv/dq_vref_level_select_tb_top.sv ====
// self-checking bench: wishbone into the controller, link into the device
// assumes design sources and the constants header are compiled first
`timescale 1ns/1ps
`include "dqvref_regs.svh"

module dq_vref_level_select_tb_top;
    // ********
    // stimulus and observed signals
    // ********
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic data_lost_clr_i = 1'b0;
    logic ref_range_o, train_enable_o, ref_settled_o, reserved_code_o, data_lost_o;
    logic [5:0] ref_level_o;
    logic [13:0] ref_percent_o;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] last = 8'h00; // word last sent to the device
    logic cal = 1'b0; // calibration flag as programmed

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    dqvref_if dqvref_if_i ();
    dqvref_ctrl #(.POWERUP_CYC(8)) dqvref_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .link(dqvref_if_i.ctrl));
    dqvref_device dqvref_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(dqvref_if_i.dev),
        .ref_range_o(ref_range_o), .ref_level_o(ref_level_o), .train_enable_o(train_enable_o),
        .ref_percent_o(ref_percent_o), .ref_settled_o(ref_settled_o),
        .reserved_code_o(reserved_code_o), .data_lost_o(data_lost_o),
        .data_lost_clr_i(data_lost_clr_i));
    dqvref_properties #(.POWERUP_CYC(8)) dqvref_properties_i (.clk_i(clk_i), .rst_i(rst_i),
        .reset_n(dqvref_if_i.reset_n), .mrw_valid(dqvref_if_i.mrw_valid),
        .mrw_data(dqvref_if_i.mrw_data));

    // ********
    // shared tasks
    // ********
    task automatic finish_test;
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // compare one value, report a mismatch at once
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // classic single wishbone cycle, waits for ack at a rising edge
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // clear the data lost flag and see it drop
    task automatic clear_lost;
        data_lost_clr_i <= 1'b1;
        @(posedge clk_i);
        data_lost_clr_i <= 1'b0;
        @(posedge clk_i);
        @(posedge clk_i);
        chk("data_lost_clr", 32'h0, 32'(data_lost_o));
    endtask

    // device state straight after any reset
    task automatic chk_reset_state;
        chk("data_lost", 32'h1, 32'(data_lost_o));
        chk("rst_percent", 32'(`DQV_BASE_R1), 32'(ref_percent_o));
        chk("rst_level", 32'h0, 32'({ref_range_o, ref_level_o}));
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_powerup;
        int n;
        n = 0;
        while (dqvref_if_i.reset_n !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk("powerup_low", 32'h1, 32'(n >= 8));
        chk_reset_state();
        clear_lost();
    endtask

    // send one word, check decode, settling time and forced training bit
    task automatic t_word(input logic [7:0] w);
        logic [7:0] sent;
        logic [13:0] pct;
        logic [31:0] rd;
        int n;
        sent = {w[7] | cal | (w[6:0] != last[6:0]), w[6:0]};
        pct = (w[6] ? `DQV_BASE_R2 : `DQV_BASE_R1) + `DQV_STEP * w[5:0];
        wb(1'b1, `DQV_REG_CMD, {24'h0, w}, rd);
        n = 0;
        @(posedge clk_i);
        chk("settling", 32'h0, 32'(ref_settled_o));
        while (ref_settled_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            n++;
        end
        chk("settle_time", 32'h1, 32'(n <= 3));
        chk("percent", 32'(pct), 32'(ref_percent_o));
        chk("range", 32'(w[6]), 32'(ref_range_o));
        chk("level", 32'(w[5:0]), 32'(ref_level_o));
        chk("train", 32'(sent[7]), 32'(train_enable_o));
        wb(1'b0, `DQV_REG_CMD, 32'h0, rd);
        chk("cmd_read", 32'(sent), rd);
        last = sent;
    endtask

    // reserved codes and an unmapped address are refused
    task automatic t_reserved(input logic [5:0] code);
        logic [31:0] rd;
        wb(1'b1, `DQV_REG_CMD, {24'h0, 2'b01, code}, rd);
        repeat (4) @(posedge clk_i);
        chk("kept_level", 32'(last[6:0]), 32'({ref_range_o, ref_level_o}));
        chk("dev_reserved", 32'h0, 32'(reserved_code_o));
        wb(1'b0, `DQV_REG_STATUS, 32'h0, rd);
        chk("reserved_flag", 32'h4, rd & 32'h4);
        wb(1'b1, `DQV_REG_STATUS, 32'h4, rd);
        wb(1'b1, 4'hC, 32'hFFFFFFFF, rd);
        wb(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        wb(1'b0, `DQV_REG_STATUS, 32'h0, rd);
        chk("reserved_w1c", 32'h0, rd & 32'h4);
    endtask

    // calibration forces training enable on an unchanged word
    task automatic t_cal;
        logic [31:0] rd;
        wb(1'b1, `DQV_REG_CAL, 32'h1, rd);
        cal = 1'b1;
        wb(1'b0, `DQV_REG_STATUS, 32'h0, rd);
        chk("cal_status", 32'h2, rd & 32'h2);
        t_word({1'b0, last[6:0]});
        wb(1'b1, `DQV_REG_CAL, 32'h0, rd);
        cal = 1'b0;
    endtask

    // warm reset: busy refusal, then device back to reset state
    task automatic t_warm;
        logic [31:0] rd;
        int n;
        wb(1'b1, `DQV_REG_CAL, 32'h2, rd);
        wb(1'b1, `DQV_REG_CMD, 32'h5, rd);
        wb(1'b0, `DQV_REG_STATUS, 32'h0, rd);
        chk("busy_flag", 32'h9, rd & 32'h9);
        n = 0;
        while (dqvref_if_i.reset_n !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        chk("warm_low", 32'h1, 32'(n >= 18));
        @(posedge clk_i);
        chk_reset_state();
        wb(1'b1, `DQV_REG_STATUS, 32'hC, rd);
        clear_lost();
    endtask

    // ********
    // main sequence and timeout
    // ********
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_powerup();
        t_word(8'h00);
        t_word(8'h01);
        t_word(8'h32);
        t_word(8'h40);
        t_word(8'hF2);
        t_word(8'h72);
        t_reserved(6'h33);
        t_reserved(6'h3F);
        t_cal();
        t_warm();
        t_word(8'h41);
        finish_test();
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end
endmodule
